// >>> design/bpam_pkg.sv
package bpam_pkg;

	// Variant selector, in words of flash.
	localparam int BPAM_SIZE_4K  = 4096;
	localparam int BPAM_SIZE_8K  = 8192;
	localparam int BPAM_SIZE_16K = 16384;

	// Pointer width and the pointer bit that carries the byte select.
	localparam int BPAM_PTR_W    = 16;
	localparam int BPAM_BYTE_BIT = 0;

	// Widest program counter among the variants; ports use this width.
	localparam int BPAM_PC_W_MAX = 14;

	// Program counter widths per variant.
	localparam int BPAM_PC_W_4K  = 12;
	localparam int BPAM_PC_W_8K  = 13;
	localparam int BPAM_PC_W_16K = 14;

	// Word-select widths per variant (32 or 64 words a page).
	localparam int BPAM_WORD_W_4K  = 5;
	localparam int BPAM_WORD_W_8K  = 6;
	localparam int BPAM_WORD_W_16K = 6;

	// Smallest boot section per variant, in words, for fuse code 11.
	localparam int BPAM_BOOT_MIN_4K  = 128;
	localparam int BPAM_BOOT_MIN_8K  = 128;
	localparam int BPAM_BOOT_MIN_16K = 256;

	// First word of the no-read-while-write region per variant.
	localparam logic [BPAM_PC_W_MAX-1:0] BPAM_NO_READ_WHILE_WRITE_REGION_4K  = 14'h0C00;
	localparam logic [BPAM_PC_W_MAX-1:0] BPAM_NO_READ_WHILE_WRITE_REGION_8K  = 14'h1C00;
	localparam logic [BPAM_PC_W_MAX-1:0] BPAM_NO_READ_WHILE_WRITE_REGION_16K = 14'h3800;

	// Fuse code width; code 11 is the smallest boot section.
	localparam int BPAM_FUSE_W = 2;

	// Operation codes issued by the core.
	typedef enum logic [2:0]
	{
		BPAM_OP_NONE   = 3'h0,
		BPAM_OP_LOAD   = 3'h1,
		BPAM_OP_ERASE  = 3'h2,
		BPAM_OP_WRITE  = 3'h3,
		BPAM_OP_READ   = 3'h4
	} bpam_op_t;

	// Decoded view of a pointer.
	typedef struct packed
	{
		logic [BPAM_PC_W_MAX-1:0] word_addr;
		logic [BPAM_PC_W_MAX-1:0] page_select_field;
		logic [BPAM_PC_W_MAX-1:0] word_select_field;
		logic                     byte_sel;
	} bpam_dec_t;

	// Boundaries derived from the fuses.
	typedef struct packed
	{
		logic [BPAM_PC_W_MAX-1:0] boot_start;
		logic [BPAM_PC_W_MAX-1:0] app_end;
		logic [BPAM_PC_W_MAX:0]   boot_words;
	} bpam_map_t;

endpackage : bpam_pkg

// >>> design/bpam_top.sv
`timescale 1ns/1ps
// Behaviour
// - 4K fuses 11..00 give 128..1024 boot words.
// - Boot section ends at top; vector is start.
// - 8K boot start 0x1F80 down to 0x1C00.
// - 16K fuses give 256..2048 words, 0x3F00..0x3800.
// - Fixed no-read-while-write region at flash top.
// - 4K: 12-bit counter, 32-word pages.
// - 8K: 13-bit counter, 64-word pages.
// - 16K: 14-bit counter, 64-word pages.
// - Counter bit n maps to pointer bit n+1.
// - Pointer bits above counter range ignored.
// - Pointer bit 0 selects byte on reads.
// - Page field targets erase and write.
// - Word field targets buffer load location.
// - Busy region blocks reads of read-while-write.
// - Core halted for no-read-while-write programming.
module bpam_top
	import bpam_pkg::*;
#(
	parameter int FLASH_WORDS = BPAM_SIZE_4K
)
(
	input  wire logic                     CLK_SYS,
	input  wire logic                     RST_B,
	input  wire logic                     BOOT_SIZE_FUSE_HI,
	input  wire logic                     BOOT_SIZE_FUSE_LO,
	input  wire logic [BPAM_PTR_W-1:0]    PTR,
	input  wire bpam_op_t                 OP,
	input  wire logic                     OP_VALID,
	input  wire logic                     PROG_DONE,
	input  wire logic                     RWW_REENABLE,
	output logic [BPAM_PC_W_MAX-1:0]      BOOT_START,
	output logic [BPAM_PC_W_MAX-1:0]      APP_END,
	output logic [BPAM_PC_W_MAX:0]        BOOT_WORDS,
	output logic [BPAM_PC_W_MAX-1:0]      NO_READ_WHILE_WRITE_REGION_START,
	output logic [BPAM_PC_W_MAX-1:0]      WORD_ADDR,
	output logic [BPAM_PC_W_MAX-1:0]      PAGE_SEL,
	output logic [BPAM_PC_W_MAX-1:0]      WORD_SEL,
	output logic                          BYTE_SEL,
	output logic                          IN_NO_READ_WHILE_WRITE_REGION,
	output logic                          IN_BOOT,
	output logic                          ERASE_STB,
	output logic                          WRITE_STB,
	output logic                          LOAD_STB,
	output logic                          READ_OK,
	output logic                          READ_BLOCKED,
	output logic                          RWW_BUSY_FLAG,
	output logic                          CPU_HALT
);

	// Every output below is a flip-flop, a decode of the state register or a constant, so the core sees a decode
	// one clock after it presents a pointer. That costs a cycle of latency but
	// keeps the pointer arithmetic off the core's own timing paths.
	// Requests are qualified by the valid line and are taken on each edge at which it is high, except while the core is halted or before the fuses are caught;
	// the core is expected to raise it once for each operation.
	// Nothing here times the programming itself: the completion pulse comes from
	// the flash array, and the re-enable pulse comes from software on the core.
	// A user must therefore never rely on this block to end a stuck operation.

	// Variant constants chosen once at elaboration.
	localparam int PC_W = (FLASH_WORDS == BPAM_SIZE_16K) ? BPAM_PC_W_16K :
		(FLASH_WORDS == BPAM_SIZE_8K) ? BPAM_PC_W_8K : BPAM_PC_W_4K;
	localparam int WORD_W = (FLASH_WORDS == BPAM_SIZE_16K) ? BPAM_WORD_W_16K :
		(FLASH_WORDS == BPAM_SIZE_8K) ? BPAM_WORD_W_8K : BPAM_WORD_W_4K;
	localparam int BOOT_MIN = (FLASH_WORDS == BPAM_SIZE_16K) ? BPAM_BOOT_MIN_16K :
		(FLASH_WORDS == BPAM_SIZE_8K) ? BPAM_BOOT_MIN_8K : BPAM_BOOT_MIN_4K;
	localparam logic [BPAM_PC_W_MAX-1:0] NO_READ_WHILE_WRITE_REGION_BASE =
		(FLASH_WORDS == BPAM_SIZE_16K) ? BPAM_NO_READ_WHILE_WRITE_REGION_16K :
		(FLASH_WORDS == BPAM_SIZE_8K) ? BPAM_NO_READ_WHILE_WRITE_REGION_8K : BPAM_NO_READ_WHILE_WRITE_REGION_4K;
	localparam logic [BPAM_PC_W_MAX:0] FLASH_TOP_W = (BPAM_PC_W_MAX+1)'(FLASH_WORDS);

	// Programming states. The held state remembers that the read-while-write
	// region has finished programming but has not yet been opened again; the
	// busy flag stays up there so that software polling it never reads a page
	// that is only half erased. The halted state covers work on the region that
	// the core itself runs from, where blocking reads is not enough and the core
	// must stop until the operation is over.
	typedef enum logic [1:0]
	{
		BPAM_IDLE,
		BPAM_PROG_RWW,
		BPAM_PROG_NO_READ_WHILE_WRITE_REGION,
		BPAM_RWW_HELD
	} bpam_state_t;

	// Keeping all state in one record means one reset and one register process,
	// so no field can be left out of the reset branch by mistake.
	// Whole module state, registered in one place.
	typedef struct packed
	{
		bpam_state_t              state;
		logic [BPAM_FUSE_W-1:0]   fuse;
		logic                     fuse_taken;
		bpam_map_t                map;
		bpam_dec_t                dec;
		logic                     in_no_read_while_write_region;
		logic                     in_boot;
		logic                     erase_stb;
		logic                     write_stb;
		logic                     load_stb;
		logic                     read_ok;
		logic                     read_blocked;
	} bpam_st_t;

	bpam_st_t st_ff;
	bpam_st_t nxt_st;

	// The section always ends at the last word of flash, so only its size is
	// decoded and the start is derived by subtraction. This keeps the three
	// variants in one expression instead of three tables that could drift apart.
	// The size is kept one bit wider than the counter so that a full-flash
	// subtraction can never wrap.
	// Fuse decode: each step down in code doubles the section size.
	function automatic bpam_map_t bpam_boot_map(input logic [BPAM_FUSE_W-1:0] code);
		bpam_map_t m;
		logic [BPAM_FUSE_W-1:0] shift;
		shift = ~code;
		m.boot_words = (BPAM_PC_W_MAX+1)'(BOOT_MIN) << shift;
		m.boot_start = BPAM_PC_W_MAX'(FLASH_TOP_W - m.boot_words);
		m.app_end    = m.boot_start - BPAM_PC_W_MAX'(1);
		return m;
	endfunction : bpam_boot_map

	// Upper pointer bits are masked rather than refused: a pointer past the top
	// of flash aliases onto low words, which is what software on the core expects.
	// Bit 0 never reaches the word address; it only picks a byte on reads.
	// Pointer decode; used for the current request and its strobes.
	function automatic bpam_dec_t bpam_decode(input logic [BPAM_PTR_W-1:0] p);
		bpam_dec_t d;
		logic [BPAM_PC_W_MAX-1:0] pc;
		pc = BPAM_PC_W_MAX'(p >> 1);
		pc = pc & BPAM_PC_W_MAX'((1 << PC_W) - 1);
		d.word_addr         = pc;
		d.page_select_field = pc >> WORD_W;
		d.word_select_field = pc & BPAM_PC_W_MAX'((1 << WORD_W) - 1);
		d.byte_sel          = p[BPAM_BYTE_BIT];
		return d;
	endfunction : bpam_decode

	// Next-state logic for the whole block.
	always_comb
	begin
		bpam_dec_t d;
		logic      busy;
		logic      no_read_while_write_region_hit;
		d        = bpam_decode(PTR);
		nxt_st   = st_ff;
		no_read_while_write_region_hit = (d.word_addr >= NO_READ_WHILE_WRITE_REGION_BASE);
		busy     = (st_ff.state != BPAM_IDLE) && (st_ff.state != BPAM_PROG_NO_READ_WHILE_WRITE_REGION);
		// Fuses are caught on the first clock after reset release only.
		// A fuse change while running has no effect until the next reset, so the
		// boundaries can never move under an operation that is in progress.
		if (!st_ff.fuse_taken)
		begin
			nxt_st.fuse       = {BOOT_SIZE_FUSE_HI, BOOT_SIZE_FUSE_LO};
			nxt_st.fuse_taken = 1'b1;
			nxt_st.map        = bpam_boot_map({BOOT_SIZE_FUSE_HI, BOOT_SIZE_FUSE_LO});
		end
		nxt_st.dec          = d;
		nxt_st.in_no_read_while_write_region      = no_read_while_write_region_hit;
		nxt_st.in_boot      = (d.word_addr >= st_ff.map.boot_start);
		nxt_st.erase_stb    = 1'b0;
		nxt_st.write_stb    = 1'b0;
		nxt_st.load_stb     = 1'b0;
		nxt_st.read_ok      = 1'b0;
		nxt_st.read_blocked = 1'b0;
		// Operations are only accepted once the boundaries are settled.
		// While the core is halted nothing is taken at all; a request seen then
		// can only be a fault on the core side and is dropped without a strobe.
		// Requests are otherwise accepted back to back, one for each edge.
		if (OP_VALID && st_ff.fuse_taken && st_ff.state != BPAM_PROG_NO_READ_WHILE_WRITE_REGION)
		begin
			unique case (OP)
				BPAM_OP_ERASE, BPAM_OP_WRITE:
				begin
					if (st_ff.state == BPAM_IDLE || st_ff.state == BPAM_RWW_HELD)
					begin
						// Only one programming operation may run at a time; a second
						// erase or write during one is refused and gives no strobe.
						nxt_st.erase_stb = (OP == BPAM_OP_ERASE);
						// On a write the core keeps the word field at zero; an erase pointer keeps its word bits.
						nxt_st.write_stb = (OP == BPAM_OP_WRITE);
						nxt_st.state = no_read_while_write_region_hit ? BPAM_PROG_NO_READ_WHILE_WRITE_REGION : BPAM_PROG_RWW;
					end
				end
				BPAM_OP_LOAD:
				begin
					nxt_st.load_stb = 1'b1;
					// A buffer load releases a held region, as the busy flag clears.
					if (st_ff.state == BPAM_RWW_HELD)
					begin
						nxt_st.state = BPAM_IDLE;
					end
				end
				BPAM_OP_READ:
				begin
					// Reads of the fixed top region are always served, because the
					// region being programmed is then the other one or the core halts.
					nxt_st.read_blocked = busy && !no_read_while_write_region_hit;
					nxt_st.read_ok      = !(busy && !no_read_while_write_region_hit);
				end
				BPAM_OP_NONE:
				begin
				end
				default:
				begin
				end
			endcase
		end
		// Completion and re-enable sequencing.
		// A completion of read-while-write programming does not open the region
		// by itself: software must first re-enable it, or start a buffer load.
		// A re-enable that meets a new request in the same cycle gives way to it,
		// so that the new operation is never lost.
		unique case (st_ff.state)
			BPAM_PROG_RWW:
			begin
				if (PROG_DONE)
				begin
					nxt_st.state = BPAM_RWW_HELD;
				end
			end
			BPAM_PROG_NO_READ_WHILE_WRITE_REGION:
			begin
				if (PROG_DONE)
				begin
					nxt_st.state = BPAM_IDLE;
				end
			end
			BPAM_RWW_HELD:
			begin
				if (RWW_REENABLE && nxt_st.state == BPAM_RWW_HELD)
				begin
					nxt_st.state = BPAM_IDLE;
				end
			end
			BPAM_IDLE:
			begin
			end
		endcase
	end

	// The reset is synchronous, so it is only seen at a clock edge; the fuse
	// capture flag is cleared with everything else and arms a fresh capture.
	// State register; reset clears all and re-arms fuse capture.
	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_B)
		begin
			st_ff <= '0;
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	// The fixed region start is a constant, the only output not taken from the state register.
	// The two status levels are plain decodes of the state register and so
	// carry no glitch of their own.
	// Outputs come straight from the registered state.
	assign BOOT_START    = st_ff.map.boot_start;
	assign APP_END       = st_ff.map.app_end;
	assign BOOT_WORDS    = st_ff.map.boot_words;
	assign NO_READ_WHILE_WRITE_REGION_START    = NO_READ_WHILE_WRITE_REGION_BASE;
	assign WORD_ADDR     = st_ff.dec.word_addr;
	assign PAGE_SEL      = st_ff.dec.page_select_field;
	assign WORD_SEL      = st_ff.dec.word_select_field;
	assign BYTE_SEL      = st_ff.dec.byte_sel;
	assign IN_NO_READ_WHILE_WRITE_REGION       = st_ff.in_no_read_while_write_region;
	assign IN_BOOT       = st_ff.in_boot;
	assign ERASE_STB     = st_ff.erase_stb;
	assign WRITE_STB     = st_ff.write_stb;
	assign LOAD_STB      = st_ff.load_stb;
	assign READ_OK       = st_ff.read_ok;
	assign READ_BLOCKED  = st_ff.read_blocked;
	assign RWW_BUSY_FLAG = (st_ff.state == BPAM_PROG_RWW) || (st_ff.state == BPAM_RWW_HELD);
	assign CPU_HALT      = (st_ff.state == BPAM_PROG_NO_READ_WHILE_WRITE_REGION);

endmodule : bpam_top

// >>> dv/bpam_assertions.sv
`timescale 1ns/1ps
module bpam_assertions
	import bpam_pkg::*;
#(
	parameter int FLASH_WORDS = BPAM_SIZE_4K
)
(
	input wire logic                  CLK_SYS,
	input wire logic                  RST_B,
	input wire logic [BPAM_PTR_W-1:0] PTR,
	input wire bpam_op_t              OP,
	input wire logic                  OP_VALID,
	input wire logic                  PROG_DONE,
	input wire logic [13:0]           BOOT_START,
	input wire logic [14:0]           BOOT_WORDS,
	input wire logic [13:0]           WORD_ADDR,
	input wire logic [13:0]           PAGE_SEL,
	input wire logic [13:0]           WORD_SEL,
	input wire logic                  BYTE_SEL,
	input wire logic                  ERASE_STB,
	input wire logic                  LOAD_STB,
	input wire logic                  READ_BLOCKED,
	input wire logic                  RWW_BUSY_FLAG,
	input wire logic                  CPU_HALT
);
	// Counter and word-select widths follow the variant, so one checker serves all three.
	localparam int PW = FLASH_WORDS == BPAM_SIZE_4K ? BPAM_PC_W_4K :
		FLASH_WORDS == BPAM_SIZE_8K ? BPAM_PC_W_8K : BPAM_PC_W_16K;
	localparam int WW = FLASH_WORDS == BPAM_SIZE_4K ? BPAM_WORD_W_4K : BPAM_WORD_W_8K;
	localparam logic [13:0] AM = 14'((1 << PW) - 1);

	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!RST_B);

	// A halted program step ends on the edge after its completion pulse.
	sequence halt_done_s;
		CPU_HALT && PROG_DONE;
	endsequence

	addr_decode_a: assert property ($past(RST_B) |-> WORD_ADDR == (14'($past(PTR) >> 1) & AM))
		else $error("word address not taken from pointer bits above bit zero");
	page_word_a: assert property (PAGE_SEL == WORD_ADDR >> WW && WORD_SEL == (WORD_ADDR & 14'((1 << WW) - 1)))
		else $error("page or word field split wrong");
	byte_pick_a: assert property ($past(RST_B) |-> BYTE_SEL == $past(PTR[0]))
		else $error("byte select not from pointer bit zero");
	erase_cause_a: assert property (ERASE_STB |-> $past(OP_VALID) && $past(OP) == BPAM_OP_ERASE ##1 !ERASE_STB)
		else $error("erase strobe without erase request");
	load_cause_a: assert property (LOAD_STB |-> $past(OP_VALID) && $past(OP) == BPAM_OP_LOAD)
		else $error("load strobe without load request");
	read_block_a: assert property (READ_BLOCKED |-> $past(RWW_BUSY_FLAG))
		else $error("read blocked while region idle");
	halt_hold_a: assert property (CPU_HALT && !PROG_DONE |=> CPU_HALT)
		else $error("halt dropped before completion");
	halt_release_a: assert property (halt_done_s |=> !CPU_HALT)
		else $error("halt kept after completion");
	boot_span_a: assert property (BOOT_WORDS != 0 |-> 15'(BOOT_START) + BOOT_WORDS == 15'(FLASH_WORDS))
		else $error("boot section does not end at last word");
	fuse_hold_a: assert property (BOOT_WORDS != 0 |=> $stable(BOOT_WORDS) && $stable(BOOT_START))
		else $error("boundaries moved without reset");
endmodule : bpam_assertions

// >>> dv/bpam_core_model.sv
`timescale 1ns/1ps
module bpam_core_model
	import bpam_pkg::*;
#(
	parameter int WORD_W = BPAM_WORD_W_4K
)
(
	input wire logic  clk,
	output logic [15:0] ptr,
	output bpam_op_t    op,
	output logic        op_valid
);
	// Idle core at time zero.
	initial
	begin
		ptr = 16'h0000;
		op = BPAM_OP_NONE;
		op_valid = 1'b0;
	end

	// One request, held for exactly one taking edge. Stores clear the byte bit and a
	// page write also clears the word field, as the core itself is obliged to.
	task automatic issue(input bpam_op_t o, input logic [15:0] p);
		@(posedge clk);
		op <= o;
		// One assignment, so the pointer is driven only once in this time step.
		ptr <= (o == BPAM_OP_READ) ? p :
			(o == BPAM_OP_WRITE) ? p & ~16'((2 << WORD_W) - 1) : p & ~16'h0001;
		op_valid <= 1'b1;
		@(posedge clk);
		op_valid <= 1'b0;
	endtask : issue
endmodule : bpam_core_model

// >>> dv/test_boot_partition_address_map.sv
`timescale 1ns/1ps
module test_boot_partition_address_map;
	import bpam_pkg::*;
	typedef struct packed {logic [15:0] p; logic [13:0] pg; logic [13:0] wd; logic b; logic n; logic ib;} bpam_row_t;
	logic        clk_sys, rst_b, fuse_hi, fuse_lo, prog_done, reen, op_valid;
	logic [15:0] ptr;
	bpam_op_t    op;
	logic [13:0] b_start, a_end, n_start, w_addr, pg_sel, wd_sel;
	logic [14:0] b_words;
	logic        b_sel, in_n, in_b, e_stb, w_stb, l_stb, rd_ok, rd_blk, busy, halt;
	int          err_total, tests_run;
	// Upper pointer bits and region edges are the awkward rows.
	bpam_row_t rows [6] = '{'{16'hFFFF, 14'h7F, 14'h1F, 1'b1, 1'b1, 1'b1}, '{16'h0042, 14'h01, 14'h01, 1'b0, 1'b0, 1'b0},
		'{16'h1FC1, 14'h7F, 14'h00, 1'b1, 1'b1, 1'b1}, '{16'hE000, 14'h00, 14'h00, 1'b0, 1'b0, 1'b0},
		'{16'h17FE, 14'h5F, 14'h1F, 1'b0, 1'b0, 1'b0}, '{16'h1800, 14'h60, 14'h00, 1'b0, 1'b1, 1'b0}};

	bpam_top #(.FLASH_WORDS(BPAM_SIZE_4K)) i_bpam_top (.CLK_SYS(clk_sys), .RST_B(rst_b),
		.BOOT_SIZE_FUSE_HI(fuse_hi), .BOOT_SIZE_FUSE_LO(fuse_lo), .PTR(ptr), .OP(op),
		.OP_VALID(op_valid), .PROG_DONE(prog_done), .RWW_REENABLE(reen), .BOOT_START(b_start),
		.APP_END(a_end), .BOOT_WORDS(b_words), .NO_READ_WHILE_WRITE_REGION_START(n_start), .WORD_ADDR(w_addr),
		.PAGE_SEL(pg_sel), .WORD_SEL(wd_sel), .BYTE_SEL(b_sel), .IN_NO_READ_WHILE_WRITE_REGION(in_n), .IN_BOOT(in_b),
		.ERASE_STB(e_stb), .WRITE_STB(w_stb), .LOAD_STB(l_stb), .READ_OK(rd_ok),
		.READ_BLOCKED(rd_blk), .RWW_BUSY_FLAG(busy), .CPU_HALT(halt));
	bpam_core_model i_bpam_core_model (.clk(clk_sys), .ptr(ptr), .op(op), .op_valid(op_valid));

	// The larger variants share the stimulus so that their maps and fields are checked too.
	for (genvar g = 0; g < 2; g = g + 1)
	begin : g_var
		logic [13:0] v_start, v_n, v_pg, v_wd;
		logic [14:0] v_words;
		bpam_top #(.FLASH_WORDS(g ? BPAM_SIZE_16K : BPAM_SIZE_8K)) i_bpam_top (.CLK_SYS(clk_sys),
			.RST_B(rst_b), .BOOT_SIZE_FUSE_HI(fuse_hi), .BOOT_SIZE_FUSE_LO(fuse_lo), .PTR(ptr),
			.OP(op), .OP_VALID(op_valid), .PROG_DONE(prog_done), .RWW_REENABLE(reen),
			.BOOT_START(v_start), .APP_END(), .BOOT_WORDS(v_words), .NO_READ_WHILE_WRITE_REGION_START(v_n),
			.WORD_ADDR(), .PAGE_SEL(v_pg), .WORD_SEL(v_wd), .BYTE_SEL(), .IN_NO_READ_WHILE_WRITE_REGION(), .IN_BOOT(),
			.ERASE_STB(), .WRITE_STB(), .LOAD_STB(), .READ_OK(), .READ_BLOCKED(),
			.RWW_BUSY_FLAG(), .CPU_HALT());
	end

	always #2 clk_sys = ~clk_sys;

	task automatic chk(input logic [14:0] got, input logic [14:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// Fuses are presented during reset so the first released edge captures them.
	task automatic do_reset(input logic [1:0] c);
		@(posedge clk_sys);
		rst_b <= 1'b0;
		{fuse_hi, fuse_lo} <= c;
		repeat (6) @(posedge clk_sys);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk_sys);
		#1;
	endtask : do_reset

	task automatic done_pulse(input logic re);
		@(posedge clk_sys);
		prog_done <= !re;
		reen <= re;
		@(posedge clk_sys);
		{prog_done, reen} <= 2'b00;
		#1;
	endtask : done_pulse

	task end_sim;
		$display("comparisons %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_sim

	// Watchdog so a stuck sequence still reaches the verdict.
	initial
	begin
		#200000;
		err_total++;
		end_sim;
	end

	initial
	begin
		{clk_sys, rst_b, prog_done, reen, err_total, tests_run} = '0;
		{fuse_hi, fuse_lo} = 2'b11;
		@(posedge clk_sys);
		#1 chk(15'(busy), 15'h0);
		chk(b_words, 15'h0);
		do_reset(2'b11);
		chk(15'(n_start), 15'h0C00);
		chk(15'(g_var[0].v_n), 15'h1C00);
		chk(15'(g_var[1].v_n), 15'h3800);
		foreach (rows[i])
		begin
			i_bpam_core_model.issue(BPAM_OP_READ, rows[i].p);
			#1 chk(15'(pg_sel), 15'(rows[i].pg));
			chk(15'(wd_sel), 15'(rows[i].wd));
			chk(15'({b_sel, in_n, in_b, rd_ok}), 15'({rows[i].b, rows[i].n, rows[i].ib, 1'b1}));
		end
		i_bpam_core_model.issue(BPAM_OP_READ, 16'hFFFF);
		#1 chk(15'(g_var[0].v_pg), 15'h7F);
		chk(15'(g_var[0].v_wd), 15'h3F);
		chk(15'(g_var[1].v_pg), 15'hFF);
		chk(15'(g_var[1].v_wd), 15'h3F);
		$display("decode test done");
		for (int c = 0; c < 4; c++)
		begin
			do_reset(2'(c));
			chk(b_words, 15'h80 << (3 - c));
			chk(g_var[0].v_words, 15'h80 << (3 - c));
			chk(15'(g_var[0].v_start), 15'h2000 - (15'h80 << (3 - c)));
			chk(g_var[1].v_words, 15'h100 << (3 - c));
			chk(15'(g_var[1].v_start), 15'h4000 - (15'h100 << (3 - c)));
			chk(15'(a_end), 15'h1000 - (15'h80 << (3 - c)) - 15'h1);
			@(posedge clk_sys) {fuse_hi, fuse_lo} <= ~2'(c);
			repeat (2) @(posedge clk_sys);
			#1 chk(15'(b_start), 15'h1000 - (15'h80 << (3 - c)));
		end
		$display("fuse test done");
		i_bpam_core_model.issue(BPAM_OP_ERASE, 16'h0100);
		#1 chk(15'({e_stb, busy, halt, pg_sel[11:0]}), {3'b110, 12'h004});
		i_bpam_core_model.issue(BPAM_OP_READ, 16'h0010);
		#1 chk(15'({rd_blk, rd_ok}), 15'h2);
		i_bpam_core_model.issue(BPAM_OP_ERASE, 16'h0200);
		#1 chk(15'(e_stb), 15'h0);
		done_pulse(1'b0);
		chk(15'(busy), 15'h1);
		done_pulse(1'b1);
		chk(15'(busy), 15'h0);
		$display("read-while-write erase test done");
		i_bpam_core_model.issue(BPAM_OP_WRITE, 16'h18BE);
		#1 chk(15'({w_stb, halt, busy, wd_sel[11:0]}), {3'b110, 12'h000});
		chk(15'(pg_sel), 15'h62);
		i_bpam_core_model.issue(BPAM_OP_LOAD, 16'h0002);
		#1 chk(15'(l_stb), 15'h0);
		done_pulse(1'b0);
		chk(15'(halt), 15'h0);
		$display("halted write test done");
		i_bpam_core_model.issue(BPAM_OP_ERASE, 16'h0000);
		done_pulse(1'b0);
		i_bpam_core_model.issue(BPAM_OP_LOAD, 16'h0006);
		#1 chk(15'({l_stb, busy, wd_sel[12:0]}), {2'b10, 13'h0003});
		$display("load release test done");
		end_sim;
	end
endmodule : test_boot_partition_address_map

bind bpam_top bpam_assertions #(.FLASH_WORDS(FLASH_WORDS)) i_bpam_assertions (.*);
